// file: adcsq_pkg.sv
// Shared constants, types and register layout of the conversion sequencer
package adcsq_pkg;

  // APB data width and register byte offsets
  localparam int          ADCSQ_DW          = 32;
  localparam logic [7:0]  OFS_MAIN_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COMMAND       = 8'h04;
  localparam logic [7:0]  OFS_ACCUM_CTRL    = 8'h08;
  localparam logic [7:0]  OFS_PRESC_CTRL    = 8'h0C;
  localparam logic [7:0]  OFS_DELAY_CTRL    = 8'h10;
  localparam logic [7:0]  OFS_SAMPLE_CTRL   = 8'h14;
  localparam logic [7:0]  OFS_EVENT_CTRL    = 8'h18;
  localparam logic [7:0]  OFS_INT_FLAGS     = 8'h1C;
  localparam logic [7:0]  OFS_RESULT        = 8'h20;

  // Field positions in main_control_register
  localparam int          BIT_ENABLE        = 0;
  localparam int          BIT_FREE_RUN      = 1;
  localparam int          BIT_LEFT_ADJUST   = 2;
  localparam int          BIT_DIFF_MODE     = 3;
  localparam int          BIT_RES10         = 4;
  // Single-bit fields elsewhere
  localparam int          BIT_START_CONV    = 0;
  localparam int          BIT_EVENT_START   = 0;
  localparam int          BIT_RESULT_READY  = 0;
  // Field positions in delay_control_register
  localparam int          POS_SAMP_DELAY    = 0;
  localparam int          POS_INIT_DELAY    = 8;

  // Reset values
  localparam logic [7:0]  RST_SAMP_LEN      = 8'h00;
  localparam logic [3:0]  RST_SAMP_DELAY    = 4'h0;
  localparam logic [7:0]  RST_INIT_DELAY    = 8'h00;
  localparam logic [3:0]  RST_PRESC         = 4'h0;
  localparam logic [2:0]  RST_ACCUM         = 3'h0;
  localparam logic [15:0] RST_RESULT        = 16'h0000;

  // Timing counts; conversion figure in half periods, sampling base in whole converter clocks
  localparam logic [9:0]  START_CYCLES      = 10'h001;
  localparam logic [9:0]  SAMPLE_BASE_ADC   = 10'h002;
  localparam logic [9:0]  CONV_HALF_TICKS   = 10'h01B;
  localparam logic [9:0]  FMT_CYCLES        = 10'h002;
  localparam int          ACCUM_FULL_LOG2   = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_INIT, ST_SAMPLE, ST_CONV, ST_FMT}
    adcsq_state_e;

  typedef struct packed {
    logic       enable;
    logic       free_run;
    logic       left_adjust;
    logic       diff_mode;
    logic       res10;
    logic       event_start;
    logic [2:0] accum_count;
    logic [3:0] presc;
    logic [3:0] samp_delay;
    logic [7:0] init_delay;
    logic [7:0] samp_length;
  } adcsq_cfg_s;

endpackage

// file: adcsq_presc.sv
// Converter clock prescaler producing half-period enable pulses
module adcsq_presc
  import adcsq_pkg::*;
#(
  parameter int PW = 4
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Control
  input  wire logic          run,
  input  wire logic [PW-1:0] div,
  // Half-period tick of the converter clock
  output logic               half_tick
);

  logic [PW-1:0] cnt_r;

  // Held cleared while idle so every conversion sees the same phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r     <= '0;
      half_tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r     <= '0;
      half_tick <= 1'b0;
    end
    else if (cnt_r == div)
    begin
      cnt_r     <= '0;
      half_tick <= 1'b1;
    end
    else
    begin
      cnt_r     <= cnt_r + 1'b1;
      half_tick <= 1'b0;
    end
  end

endmodule

// file: adcsq_top.sv
// Conversion sequencer with APB registers, accumulation and result formatting
// Function
// RULE1: Software starts conversion by writing start bit
// RULE2: Start-up phase lasts at most two cycles
// RULE3: Default sampling lasts two converter clocks
// RULE4: Conversion phase lasts 13.5 converter clocks
// RULE5: Two peripheral cycles of result formatting
// RULE6: Completion writes result, sets ready flag
// RULE7: Start bit stays set over all samples
// RULE8: One start-up, then per-sample sample/convert/format
// RULE9: Free-running restarts immediately after completion
// RULE10: Free-running flags every result, allows accumulation
// RULE11: Software stops free-run before changing settings
// RULE12: Sampling lasts two plus delay plus length
// RULE13: Delay and length count converter clocks
// RULE14: Init delay holds off sampling after enable
// RULE15: Result stored in 16-bit result register
// RULE16: Single-ended results are unsigned
// RULE17: Differential results sign-extended two's complement
// RULE18: Right adjust by default
// RULE19: Left adjust puts MSBs in high byte
// RULE20: Prescaler held reset while idle
// RULE21: Event rising edge starts conversion
// RULE22: Accumulator cleared at each new conversion
// RULE23: Over 16 samples, LSBs truncated to fit
//
// Chosen here: the register offsets and the APB interface to the registers.
module adcsq_top
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Event system
  input  wire logic        EVENT_IN,
  output logic             RESULT_EVENT,
  // Analog core
  input  wire logic [11:0] ADC_CODE,
  output logic             SAMPLE_HOLD,
  output logic             CONVERTING,
  output logic             BUSY
);

  adcsq_cfg_s   cfg_r;
  adcsq_state_e state_r;
  logic [9:0]   cnt_r;
  logic [7:0]   smp_left_r;
  logic signed [19:0] acc_r;
  logic [15:0]  result_r;
  logic         ready_flag_r;
  logic         init_pend_r;
  logic         ev_meta_r;
  logic         ev_sync_r;
  logic         ev_prev_r;
  logic         half_tick;
  logic         wr_en;
  logic         rd_en;
  logic         start_req;
  logic         ev_rise;
  logic         phase_done;
  logic         last_sample;
  logic [9:0]   phase_len;

  // Sample-to-signed conversion for both resolutions and modes
  function automatic logic signed [19:0] to_sample(input logic [11:0] code,
                                                   input logic diff,
                                                   input logic res10);
    logic signed [19:0] v;
    v = '0;
    if (res10)
      v = diff ? {{10{code[11]}}, code[11:2]} : {10'h000, code[11:2]}; // RULE16 RULE17
    else
      v = diff ? {{8{code[11]}}, code} : {8'h00, code}; // RULE16 RULE17
    return v;
  endfunction

  // Truncation and adjustment of the accumulated sum into 16 bits
  function automatic logic [15:0] fmt_result(input logic signed [19:0] acc,
                                             input logic [2:0] n,
                                             input logic res10,
                                             input logic left);
    logic signed [19:0] t;
    logic [4:0]         width;
    logic [2:0]         shr;
    width = (res10 ? 5'd10 : 5'd12);
    shr   = '0;
    if (n > 3'(ACCUM_FULL_LOG2))
    begin
      shr   = n - 3'(ACCUM_FULL_LOG2); // RULE23
      width = width + 5'(ACCUM_FULL_LOG2);
    end
    else
      width = width + 5'(n);
    t = acc >>> shr;
    if (left)
      return t[15:0] << (5'd16 - width); // RULE19
    else
      return t[15:0]; // RULE18
  endfunction

  // APB access answers one cycle into the access phase
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_en = PSEL && PENABLE && !PREADY && !PWRITE;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      PREADY <= 1'b0;
    else
      PREADY <= PSEL && PENABLE && !PREADY;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && PENABLE && !PREADY)
    begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
      if (PADDR == OFS_MAIN_CTRL)
      begin
        if (rd_en)
          PRDATA[4:0] <= {cfg_r.res10, cfg_r.diff_mode, cfg_r.left_adjust,
                          cfg_r.free_run, cfg_r.enable};
      end
      else if (PADDR == OFS_COMMAND)
      begin
        if (rd_en)
          PRDATA[BIT_START_CONV] <= BUSY; // RULE7
      end
      else if (PADDR == OFS_ACCUM_CTRL)
      begin
        if (rd_en)
          PRDATA[2:0] <= cfg_r.accum_count;
      end
      else if (PADDR == OFS_PRESC_CTRL)
      begin
        if (rd_en)
          PRDATA[3:0] <= cfg_r.presc;
      end
      else if (PADDR == OFS_DELAY_CTRL)
      begin
        if (rd_en)
        begin
          PRDATA[POS_SAMP_DELAY+:4] <= cfg_r.samp_delay;
          PRDATA[POS_INIT_DELAY+:8] <= cfg_r.init_delay;
        end
      end
      else if (PADDR == OFS_SAMPLE_CTRL)
      begin
        if (rd_en)
          PRDATA[7:0] <= cfg_r.samp_length;
      end
      else if (PADDR == OFS_EVENT_CTRL)
      begin
        if (rd_en)
          PRDATA[BIT_EVENT_START] <= cfg_r.event_start;
      end
      else if (PADDR == OFS_INT_FLAGS)
      begin
        if (rd_en)
          PRDATA[BIT_RESULT_READY] <= ready_flag_r;
      end
      else if (PADDR == OFS_RESULT)
      begin
        if (rd_en)
          PRDATA[15:0] <= result_r;
      end
      else
        PSLVERR <= 1'b1;
    end
    else
      PSLVERR <= 1'b0;
  end

  // Configuration registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cfg_r             <= '0;
      cfg_r.accum_count <= RST_ACCUM;
      cfg_r.presc       <= RST_PRESC;
      cfg_r.samp_delay  <= RST_SAMP_DELAY;
      cfg_r.init_delay  <= RST_INIT_DELAY;
      cfg_r.samp_length <= RST_SAMP_LEN;
    end
    else if (wr_en)
    begin
      if (PADDR == OFS_MAIN_CTRL)
      begin
        cfg_r.enable      <= PWDATA[BIT_ENABLE];
        cfg_r.free_run    <= PWDATA[BIT_FREE_RUN];
        cfg_r.left_adjust <= PWDATA[BIT_LEFT_ADJUST];
        cfg_r.diff_mode   <= PWDATA[BIT_DIFF_MODE];
        cfg_r.res10       <= PWDATA[BIT_RES10];
      end
      else if (PADDR == OFS_ACCUM_CTRL)
        cfg_r.accum_count <= PWDATA[2:0];
      else if (PADDR == OFS_PRESC_CTRL)
        cfg_r.presc <= PWDATA[3:0];
      else if (PADDR == OFS_DELAY_CTRL)
      begin
        cfg_r.samp_delay <= PWDATA[POS_SAMP_DELAY+:4];
        cfg_r.init_delay <= PWDATA[POS_INIT_DELAY+:8];
      end
      else if (PADDR == OFS_SAMPLE_CTRL)
        cfg_r.samp_length <= PWDATA[7:0];
      else if (PADDR == OFS_EVENT_CTRL)
        cfg_r.event_start <= PWDATA[BIT_EVENT_START];
    end
  end

  // Event input crosses in from outside; edge taken after the second flop
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ev_meta_r <= 1'b0;
      ev_sync_r <= 1'b0;
      ev_prev_r <= 1'b0;
    end
    else
    begin
      ev_meta_r <= EVENT_IN;
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  assign ev_rise   = ev_sync_r && !ev_prev_r && cfg_r.event_start; // RULE21
  assign start_req = cfg_r.enable && (ev_rise ||
                     (wr_en && PADDR == OFS_COMMAND && PWDATA[BIT_START_CONV])); // RULE1

  // Init delay is owed once per enable
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      init_pend_r <= 1'b1;
    else if (!cfg_r.enable)
      init_pend_r <= 1'b1;
    else if (state_r == ST_INIT && phase_done)
      init_pend_r <= 1'b0; // RULE14
  end

  adcsq_presc #(
    .PW (4)
  ) u_presc (
    .clk       (CLK),
    .rst_n     (RST_N),
    .run       (BUSY && state_r != ST_START), // RULE20
    .div       (cfg_r.presc),
    .half_tick (half_tick)
  );

  // Phase lengths: converter phases in half ticks, others in clock cycles
  always_comb
  begin
    phase_len = START_CYCLES;
    case (state_r)
      ST_START:  phase_len = START_CYCLES; // RULE2
      ST_INIT:   phase_len = {1'b0, cfg_r.init_delay, 1'b0}; // RULE14
      ST_SAMPLE: phase_len = (SAMPLE_BASE_ADC + 10'(cfg_r.samp_delay)
                              + 10'(cfg_r.samp_length)) << 1; // RULE3 RULE12 RULE13
      ST_CONV:   phase_len = CONV_HALF_TICKS; // RULE4
      ST_FMT:    phase_len = FMT_CYCLES; // RULE5
      default:   phase_len = START_CYCLES;
    endcase
  end

  assign phase_done  = (state_r == ST_INIT || state_r == ST_SAMPLE || state_r == ST_CONV)
                       ? (half_tick && cnt_r + 10'h001 >= phase_len) || phase_len == '0
                       : (cnt_r + 10'h001 >= phase_len);
  assign last_sample = (smp_left_r == 8'h01);

  // Sequencer
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      smp_left_r <= '0;
      acc_r      <= '0;
    end
    else if (!cfg_r.enable)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= '0;
          if (start_req)
            state_r <= ST_START;
        end
        ST_START:
        begin
          acc_r      <= '0; // RULE22
          smp_left_r <= 8'h01 << cfg_r.accum_count;
          cnt_r      <= '0;
          if (phase_done)
            state_r <= init_pend_r ? ST_INIT : ST_SAMPLE; // RULE8 RULE14
        end
        ST_INIT, ST_SAMPLE, ST_CONV:
        begin
          if (phase_done)
          begin
            cnt_r   <= '0;
            state_r <= (state_r == ST_INIT) ? ST_SAMPLE :
                       (state_r == ST_SAMPLE) ? ST_CONV : ST_FMT;
          end
          else if (half_tick)
            cnt_r <= cnt_r + 10'h001;
        end
        ST_FMT:
        begin
          if (cnt_r == '0)
            acc_r <= acc_r + to_sample(ADC_CODE, cfg_r.diff_mode, cfg_r.res10);
          cnt_r <= cnt_r + 10'h001;
          if (phase_done)
          begin
            cnt_r      <= '0;
            smp_left_r <= smp_left_r - 8'h01;
            if (!last_sample)
              state_r <= ST_SAMPLE; // RULE8
            else if (cfg_r.free_run)
              state_r <= ST_START; // RULE9
            else
              state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Result register and completion event
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      result_r     <= RST_RESULT;
      RESULT_EVENT <= 1'b0;
    end
    else
    begin
      RESULT_EVENT <= 1'b0;
      if (state_r == ST_FMT && phase_done && last_sample)
      begin
        result_r     <= fmt_result(acc_r, cfg_r.accum_count, cfg_r.res10,
                                   cfg_r.left_adjust); // RULE6 RULE15
        RESULT_EVENT <= 1'b1; // RULE10
      end
    end
  end

  // Ready flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      ready_flag_r <= 1'b0;
    else if (state_r == ST_FMT && phase_done && last_sample)
      ready_flag_r <= 1'b1; // RULE6 RULE10
    else if (wr_en && PADDR == OFS_INT_FLAGS && PWDATA[BIT_RESULT_READY])
      ready_flag_r <= 1'b0;
  end

  // Status outputs to the analog core and software
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      BUSY        <= 1'b0;
      SAMPLE_HOLD <= 1'b0;
      CONVERTING  <= 1'b0;
    end
    else
    begin
      // Stays high across every sample of a burst
      BUSY        <= cfg_r.enable && (start_req || (state_r != ST_IDLE &&
                     !(state_r == ST_FMT && phase_done && last_sample
                       && !cfg_r.free_run))); // RULE7
      // Raised on entry, so the pin is as wide as the sampling phase
      SAMPLE_HOLD <= cfg_r.enable && (state_r == ST_SAMPLE && !phase_done ||
                     phase_done && (state_r == ST_INIT ||
                     state_r == ST_START && !init_pend_r ||
                     state_r == ST_FMT && !last_sample)); // RULE3 RULE12
      CONVERTING  <= cfg_r.enable && (state_r == ST_CONV && !phase_done ||
                     state_r == ST_SAMPLE && phase_done);
    end
  end

endmodule

// file: adcsq_top_sva.sv
// Port-level assertions for the conversion sequencer
module adcsq_top_sva
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // APB slave
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Event system
  input wire logic        EVENT_IN,
  input wire logic        RESULT_EVENT,
  // Analog core
  input wire logic [11:0] ADC_CODE,
  input wire logic        SAMPLE_HOLD,
  input wire logic        CONVERTING,
  input wire logic        BUSY
);
  logic en_r;

  // Shadow of the enable bit, so starts can be judged at the ports
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      en_r <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_MAIN_CTRL)
      en_r <= PWDATA[BIT_ENABLE];
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ready_late_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("PREADY not in second access cycle");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("PREADY longer than one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("PSLVERR without PREADY");
  start_busy_a: assert property (PSEL && PENABLE && PREADY && PWRITE &&
    PADDR == OFS_COMMAND && PWDATA[0] && en_r && !BUSY |=> BUSY)
    else $error("start write did not raise BUSY");
  phase_busy_a: assert property ((SAMPLE_HOLD || CONVERTING) |-> BUSY)
    else $error("phase active while not busy");
  phase_excl_a: assert property (!(SAMPLE_HOLD && CONVERTING))
    else $error("sampling and converting overlap");
  hold_conv_a: assert property ($fell(SAMPLE_HOLD) && BUSY |-> CONVERTING)
    else $error("conversion does not follow sampling");
  conv_len_a: assert property ($rose(CONVERTING) |-> CONVERTING [*8])
    else $error("conversion phase too short");
  fmt_len_a: assert property ($fell(CONVERTING) |-> !RESULT_EVENT && !SAMPLE_HOLD
    ##1 !RESULT_EVENT ##[1:3] (RESULT_EVENT || SAMPLE_HOLD))
    else $error("formatting not two cycles");
  event_pulse_a: assert property (RESULT_EVENT |=> !RESULT_EVENT)
    else $error("RESULT_EVENT longer than one cycle");
  busy_end_a: assert property ($fell(BUSY) && en_r |-> ##[0:1] RESULT_EVENT)
    else $error("BUSY fell without a result");
endmodule

bind adcsq_top adcsq_top_sva i_adcsq_top_sva (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_IN(EVENT_IN), .RESULT_EVENT(RESULT_EVENT),
  .ADC_CODE(ADC_CODE), .SAMPLE_HOLD(SAMPLE_HOLD), .CONVERTING(CONVERTING), .BUSY(BUSY));

// file: adcsq_core_model.sv
// Behavioural analog core returning a set code
module adcsq_core_model
  import adcsq_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Sequencer side
  input  wire logic        busy,
  input  wire logic [11:0] code,
  output logic      [11:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ns;

  // Output not held between operations: inverse exposes early sampling
  always_ff @(posedge clk)
  begin
    adc_code <= busy ? code : ~code;
  end
endmodule

// file: adcsq_top_tb_top.sv
// Self-checking bench for the conversion sequencer
module adcsq_top_tb_top
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, psel, penable, pwrite, evt, pready, pslverr;
  logic        res_ev, sh, cv, busy, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [11:0] code, adc_code;
  int          errors = 0, checks_done = 0, cyc = 0;
  int          sh_n = 0, sh_len = 0, cv_n = 0, cv_len = 0, ev_cnt = 0, e0;
  int          lead_n = 0, lead_len = 0;
  logic [7:0]  fm_main [10] = '{8'h01, 8'h05, 8'h11, 8'h15, 8'h09, 8'h09, 8'h19,
                                8'h0D, 8'h09, 8'h19};
  logic [11:0] fm_code [10] = '{12'hABC, 12'hABC, 12'hABC, 12'hABC, 12'h7FF,
                                12'h800, 12'h800, 12'h800, 12'hFFF, 12'h7FF};
  logic [15:0] fm_exp [10]  = '{16'h0ABC, 16'hABC0, 16'h02AF, 16'hABC0, 16'h07FF,
                                16'hF800, 16'hFE00, 16'h8000, 16'hFFFF, 16'h01FF};
  logic [2:0]  acc_n [4]    = '{3'h1, 3'h4, 3'h5, 3'h7};
  logic [15:0] acc_exp [4]  = '{16'h1578, 16'hABC0, 16'hABC0, 16'hABC0};

  adcsq_top i_adcsq_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVENT_IN(evt), .RESULT_EVENT(res_ev), .ADC_CODE(adc_code),
    .SAMPLE_HOLD(sh), .CONVERTING(cv), .BUSY(busy));
  adcsq_core_model i_adcsq_core_model (.clk(clk), .busy(busy), .code(code),
    .adc_code(adc_code));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Phase lengths and result events seen at the ports
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sh === 1'b1) sh_n <= sh_n + 1;
    else if (sh_n != 0) begin sh_len <= sh_n; sh_n <= 0; end
    if (cv === 1'b1) cv_n <= cv_n + 1;
    else if (cv_n != 0) begin cv_len <= cv_n; cv_n <= 0; end
    if (res_ev === 1'b1) ev_cnt <= ev_cnt + 1;
    // Cycles of an operation before sampling begins
    if (busy !== 1'b1)
      lead_n <= 0;
    else if (sh === 1'b1 && lead_n >= 0)
    begin
      lead_len <= lead_n;
      lead_n   <= -1;
    end
    else if (lead_n >= 0)
      lead_n <= lead_n + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask

  // Wait bounded: a hang here must not stall the run
  task automatic wait_until(input logic ev);
    int n;
    n = 0;
    @(posedge clk);
    while ((ev ? res_ev : busy) !== ev && n < 6000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 6000, 1);
  endtask

  task automatic conv(input logic [7:0] main, input logic [15:0] exp);
    wr(OFS_MAIN_CTRL, {24'h0, main});
    wr(OFS_COMMAND, 32'h1);
    @(negedge clk);
    chk(busy, 1);
    wait_until(1'b1);
    @(negedge clk);
    chk(busy, 0);
    rd(OFS_RESULT, {16'h0, exp}, 1'b0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = 1'b0;
    code = 12'hABC;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_RESULT, 32'h0, 1'b0);
    rd(OFS_INT_FLAGS, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    wr(OFS_COMMAND, 32'h1);
    repeat (3) @(negedge clk);
    chk(busy, 0);
    $display("Test registers done");
    wr(OFS_PRESC_CTRL, 32'h1);
    wr(OFS_DELAY_CTRL, 32'h1);
    wr(OFS_SAMPLE_CTRL, 32'h2);
    rd(OFS_DELAY_CTRL, 32'h1, 1'b0);
    conv(8'h01, 16'h0ABC);
    chk(sh_len, 2 * (2 + 1 + 2) * 2);
    chk(cv_len, 27 * 2);
    rd(OFS_INT_FLAGS, 32'h1, 1'b0);
    wr(OFS_INT_FLAGS, 32'h1);
    rd(OFS_INT_FLAGS, 32'h0, 1'b0);
    wr(OFS_PRESC_CTRL, 32'h0);
    wr(OFS_DELAY_CTRL, 32'h0);
    wr(OFS_SAMPLE_CTRL, 32'h0);
    $display("Test timing done");
    for (int i = 0; i < 10; i++)
    begin
      code <= fm_code[i];
      conv(fm_main[i], fm_exp[i]);
    end
    $display("Test formats done");
    code <= 12'hABC;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_ACCUM_CTRL, {29'h0, acc_n[i]});
      e0 = ev_cnt;
      conv(8'h01, acc_exp[i]);
      chk(ev_cnt - e0, 1);
    end
    $display("Test accumulation done");
    wr(OFS_ACCUM_CTRL, 32'h1);
    wr(OFS_MAIN_CTRL, 32'h3);
    wr(OFS_COMMAND, 32'h1);
    wait_until(1'b1);
    wr(OFS_INT_FLAGS, 32'h1);
    wait_until(1'b1);
    @(negedge clk);
    chk(busy, 1);
    rd(OFS_COMMAND, 32'h1, 1'b0);
    rd(OFS_INT_FLAGS, 32'h1, 1'b0);
    wr(OFS_MAIN_CTRL, 32'h1);
    wait_until(1'b0);
    rd(OFS_RESULT, 32'h1578, 1'b0);
    $display("Test free running done");
    wr(OFS_ACCUM_CTRL, 32'h0);
    wr(OFS_EVENT_CTRL, 32'h1);
    code <= 12'h123;
    evt <= 1'b1;
    wait_until(1'b1);
    evt <= 1'b0;
    rd(OFS_RESULT, 32'h0123, 1'b0);
    $display("Test event start done");
    wr(OFS_DELAY_CTRL, 32'h0300);
    wr(OFS_MAIN_CTRL, 32'h0);
    conv(8'h01, 16'h0123);
    chk(lead_len >= 7 && lead_len <= 9, 1);
    conv(8'h01, 16'h0123);
    chk(lead_len <= 2, 1);
    $display("Test init delay done");
    conclude();
  end
endmodule
